// ### src/twd_pkg.sv
// twd_pkg: constants for the touch widget detector
// assumes 32-bit register port, byte offsets, one sensor sample per cycle
package twd_pkg;

   // sizes
   localparam int NSENS    = 32;
   localparam int GRP_MAX  = 8;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_FINGER  = 8'h04;
   localparam logic [7:0] OFF_NOISE   = 8'h08;
   localparam logic [7:0] OFF_HYST    = 8'h0C;
   localparam logic [7:0] OFF_DEB     = 8'h10;
   localparam logic [7:0] OFF_SCANRES = 8'h14;
   localparam logic [7:0] OFF_ELEMS   = 8'h18;
   localparam logic [7:0] OFF_POSRES  = 8'h1C;
   localparam logic [7:0] OFF_GROUP   = 8'h20;
   localparam logic [7:0] OFF_GENIDX  = 8'h24;
   localparam logic [7:0] OFF_ACTIVE  = 8'h30;
   localparam logic [7:0] OFF_POS     = 8'h34;
   localparam logic [7:0] OFF_TPXY    = 8'h38;
   localparam logic [7:0] OFF_GENRAW  = 8'h3C;
   localparam logic [7:0] OFF_STATUS  = 8'h40;

   // control fields
   localparam int CTRL_WIDE   = 0;
   localparam int CTRL_DIPLEX = 1;
   localparam int CTRL_FLT_LO = 4;

   // values after reset
   localparam logic [15:0] FINGER_RST  = 16'h0064;
   localparam logic [15:0] NOISE_RST   = 16'h0014;
   localparam logic [15:0] HYST_RST    = 16'h000A;
   localparam logic [7:0]  DEB_RST     = 8'h05;
   localparam logic [4:0]  SCANRES_RST = 5'h0A;
   localparam logic [5:0]  ELEMS_RST   = 6'h05;
   localparam logic [7:0]  POSRES_RST  = 8'h64;
   localparam logic [3:0]  GRP_RST     = 4'h8;

   // limits
   localparam logic [4:0] SCANRES_MIN = 5'h06;
   localparam logic [4:0] SCANRES_MAX = 5'h10;
   localparam logic [5:0] ELEMS_MIN   = 6'h02;
   localparam logic [5:0] ELEMS_MAX   = 6'h20;
   localparam logic [5:0] DIPLEX_MIN  = 6'h05;

   // matrix / touchpad sensor groups
   localparam logic [4:0] COL_BASE = 5'h10;
   localparam logic [4:0] ROW_BASE = 5'h18;

   typedef enum logic [2:0] {
      FLT_NONE = 3'h0,
      FLT_MED  = 3'h1,
      FLT_AVG  = 3'h2,
      FLT_IIR2 = 3'h3,
      FLT_IIR4 = 3'h4,
      FLT_JIT  = 3'h5
   } twd_flt_e;

   localparam twd_flt_e FLT_RST = FLT_IIR4;

endpackage

// ### src/twd_pos_if.sv
// twd_pos_if: slider position handed to the position filter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface twd_pos_if;
   logic       vld;
   logic       clr;
   logic [7:0] din;
   logic [2:0] sel;
   logic [7:0] dout;
   modport src (output vld, output clr, output din, output sel, input dout);
   modport flt (input vld, input clr, input din, input sel, output dout);
endinterface

// ### src/twd_pos_filter.sv
// twd_pos_filter: one selectable position noise filter per slider
// assumes one vld pulse per new centroid, clr when the finger leaves
`timescale 1ns/1ps
module twd_pos_filter
   import twd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   twd_pos_if.flt   pf
);

   logic [7:0] h1_reg;
   logic [7:0] h2_reg;
   logic [1:0] fill_reg;
   logic [7:0] out_reg;
   logic [7:0] out_next;
   logic [9:0] sum3;

   function automatic logic [7:0] med3(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] c);
      if ((a >= b && a <= c) || (a <= b && a >= c)) return a;
      if ((b >= a && b <= c) || (b <= a && b >= c)) return b;
      return c;
   endfunction

   // next output for the chosen filter; history not yet full passes input
   always_comb begin
      sum3 = 10'(pf.din) + 10'(h1_reg) + 10'(h2_reg);
      out_next = pf.din;
      if (fill_reg == 2'h2) begin
         case (twd_flt_e'(pf.sel))
            FLT_NONE: out_next = pf.din;
            FLT_MED:  out_next = med3(pf.din, h1_reg, h2_reg);
            FLT_AVG:  out_next = 8'(sum3 / 10'h003);
            FLT_IIR2: out_next = 8'((9'(pf.din) + 9'(out_reg)) >> 1);
            FLT_IIR4: out_next = 8'((10'(pf.din) + 10'h003 * 10'(out_reg)) >> 2);
            FLT_JIT: begin
               if (pf.din > h1_reg && out_reg != 8'hFF) out_next = out_reg + 8'h01;
               else if (pf.din < h1_reg && out_reg != 8'h00) out_next = out_reg - 8'h01;
               else out_next = out_reg;
            end
            default:  out_next = pf.din;
         endcase
      end
   end

   // history and output; one filter at a time by construction
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         h1_reg   <= 8'h00;
         h2_reg   <= 8'h00;
         fill_reg <= 2'h0;
         out_reg  <= 8'h00;
      end else if (pf.clr) begin
         fill_reg <= 2'h0;
      end else if (pf.vld) begin
         h1_reg   <= pf.din;
         h2_reg   <= (fill_reg == 2'h0) ? pf.din : h1_reg;
         fill_reg <= 2'h2;
         out_reg  <= out_next;
      end
   end

   assign pf.dout = out_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_iir4;
      (pf.vld && !pf.clr && fill_reg == 2'h2 && pf.sel == FLT_IIR4) |=>
         out_reg == 8'((10'($past(pf.din)) + 10'h003 * 10'($past(out_reg))) >> 2);
   endproperty
   a_iir4: assert property (p_iir4) else $error("iir quarter output wrong");

   property p_jit;
      (pf.vld && !pf.clr && fill_reg == 2'h2 && pf.sel == FLT_JIT && pf.din > h1_reg
       && out_reg != 8'hFF) |=> out_reg == $past(out_reg) + 8'h01;
   endproperty
   a_jit: assert property (p_jit) else $error("jitter step up missing");

endmodule

// ### src/twd_top.sv
// twd_top: touch decision, baseline, slider/touchpad centroid, matrix, generic
// assumes one sample per smp_valid and a frame_done pulse after each full scan
// Function
// - a sensor reads touched when its difference exceeds the finger level
// - level settings span 1..255 in 8-bit mode, 1..65535 in 16-bit mode
// - baseline is held whenever a sensor's difference exceeds the noise level
// - inactive sensor arms only above finger level plus hysteresis
// - active sensor releases only below finger level minus hysteresis
// - activation needs the configured consecutive samples above, 1..255, default 5
// - scan resolution 6..16 bits, default 10; raw count capped at 2^N-1
// - linear slider has 2..32 elements, default 5
// - slider position spans the position resolution 1..255, default 100
// - diplexed slider shares one pin between two elements, needs 5+ elements
// - centroid ignores element differences below the noise level
// - one position filter per slider: none, median, average, iir, jitter
// - matrix press only where an active row meets an active column
// - touchpad gives separate x and y coordinates
// - generic sensor passes its raw count untouched
// - iir quarter: new/4 plus three quarters of previous output
// - jitter: step previous output by one toward the newest value's direction
// - median picks middle of last three, average their mean
`timescale 1ns/1ps
module twd_top
   import twd_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        smp_valid,
   input  wire logic [4:0]  smp_idx,
   input  wire logic [15:0] smp_raw,
   input  wire logic        frame_done,
   output logic      [31:0] sensor_active,
   output logic      [7:0]  slider_pos,
   output logic             slider_touch,
   output logic      [7:0]  tp_x,
   output logic      [7:0]  tp_y,
   output logic      [63:0] matrix_press,
   output logic      [15:0] generic_raw,
   output logic             cfg_err
);

   typedef enum logic [3:0] {
      CS_IDLE = 4'h1,
      CS_ACC  = 4'h2,
      CS_DIV  = 4'h4,
      CS_DONE = 4'h8
   } twd_cst_e;

   // configuration
   logic [7:0]  ctrl_reg;
   logic [15:0] finger_level_reg;
   logic [15:0] noise_reg;
   logic [15:0] hyst_reg;
   logic [7:0]  deb_reg;
   logic [4:0]  scanres_reg;
   logic [5:0]  elems_reg;
   logic [7:0]  posres_reg;
   logic [3:0]  cols_reg;
   logic [3:0]  rows_reg;
   logic [4:0]  genidx_reg;

   // per-sensor state
   logic [15:0] base_mem [NSENS];
   logic [15:0] diff_mem [NSENS];
   logic [7:0]  deb_mem  [NSENS];
   logic [31:0] bvalid_reg;
   logic [31:0] act_reg;

   // centroid engine
   twd_cst_e    cst_reg;
   logic [1:0]  pass_reg;
   logic [5:0]  i_reg;
   logic [20:0] sw_reg;
   logic [39:0] num_reg;
   logic [39:0] den_reg;
   logic [7:0]  q_reg;
   logic        touch_reg;

   logic        wide;
   logic [15:0] fl;
   logic [15:0] nz;
   logic [15:0] hy;
   logic [16:0] on_thr;
   logic [15:0] off_thr;
   logic [15:0] raw_c;
   logic [15:0] bl;
   logic [15:0] diff;
   logic        act_c;
   logic        deb_hit;
   logic [5:0]  cnt_c;
   logic [5:0]  pins;
   logic [15:0] d_c;
   logic [4:0]  idx_q;

   twd_pos_if pf ();

   // level clamp: 8-bit widgets see the low byte, zero reads as one
   function automatic logic [15:0] lvl(input logic [15:0] v, input logic w);
      logic [15:0] x;
      x = w ? v : {8'h00, v[7:0]};
      return (x == 16'h0000) ? 16'h0001 : x;
   endfunction

   // raw count capped at 2^N-1 with N held to 6..16
   function automatic logic [15:0] raw_lim(input logic [15:0] r, input logic [4:0] n);
      logic [4:0]  nn;
      logic [16:0] m;
      nn = (n < SCANRES_MIN) ? SCANRES_MIN : (n > SCANRES_MAX) ? SCANRES_MAX : n;
      m  = (17'h00001 << nn) - 17'h00001;
      return (r > m[15:0]) ? m[15:0] : r;
   endfunction

   // sensor index of element i in the current pass
   function automatic logic [4:0] sens_of(input logic [1:0] p, input logic [5:0] i,
                                          input logic dpx, input logic [5:0] np);
      case (p)
         2'h0:    sens_of = (dpx && i >= np) ? 5'(i - np) : 5'(i);
         2'h1:    sens_of = COL_BASE + 5'(i);
         default: sens_of = ROW_BASE + 5'(i);
      endcase
   endfunction

   // thresholds and this sample's difference
   always_comb begin
      wide    = ctrl_reg[CTRL_WIDE];
      fl      = lvl(finger_level_reg, wide);
      nz      = lvl(noise_reg, wide);
      hy      = lvl(hyst_reg, wide);
      on_thr  = 17'(fl) + 17'(hy);
      off_thr = (fl > hy) ? fl - hy : 16'h0000;
      raw_c   = raw_lim(smp_raw, scanres_reg);
      bl      = base_mem[smp_idx];
      diff    = (bvalid_reg[smp_idx] && raw_c > bl) ? raw_c - bl : 16'h0000;
      act_c   = act_reg[smp_idx];
      deb_hit = (deb_mem[smp_idx] + 8'h01 >= ((deb_reg == 8'h00) ? 8'h01 : deb_reg));
   end

   // configuration errors block the slider pass
   assign cfg_err = (elems_reg < ELEMS_MIN) || (elems_reg > ELEMS_MAX) ||
                    (ctrl_reg[CTRL_DIPLEX] && elems_reg < DIPLEX_MIN);
   assign pins    = ctrl_reg[CTRL_DIPLEX] ? 6'((7'(elems_reg) + 7'h01) >> 1) : elems_reg;

   // register writes
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg         <= {1'b0, FLT_RST, 4'h0};
         finger_level_reg <= FINGER_RST;
         noise_reg        <= NOISE_RST;
         hyst_reg         <= HYST_RST;
         deb_reg          <= DEB_RST;
         scanres_reg      <= SCANRES_RST;
         elems_reg        <= ELEMS_RST;
         posres_reg       <= POSRES_RST;
         cols_reg         <= GRP_RST;
         rows_reg         <= GRP_RST;
         genidx_reg       <= 5'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            OFF_CTRL:    ctrl_reg         <= reg_wdata[7:0];
            OFF_FINGER:  finger_level_reg <= reg_wdata[15:0];
            OFF_NOISE:   noise_reg        <= reg_wdata[15:0];
            OFF_HYST:    hyst_reg         <= reg_wdata[15:0];
            OFF_DEB:     deb_reg          <= reg_wdata[7:0];
            OFF_SCANRES: scanres_reg      <= reg_wdata[4:0];
            OFF_ELEMS:   elems_reg        <= reg_wdata[5:0];
            OFF_POSRES:  posres_reg       <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
            OFF_GROUP: begin
               cols_reg <= (reg_wdata[3:0] > 4'h8) ? 4'h8 : reg_wdata[3:0];
               rows_reg <= (reg_wdata[7:4] > 4'h8) ? 4'h8 : reg_wdata[7:4];
            end
            OFF_GENIDX:  genidx_reg       <= reg_wdata[4:0];
            default: ;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            OFF_CTRL:    reg_rdata <= {24'h000000, ctrl_reg};
            OFF_FINGER:  reg_rdata <= {16'h0000, finger_level_reg};
            OFF_NOISE:   reg_rdata <= {16'h0000, noise_reg};
            OFF_HYST:    reg_rdata <= {16'h0000, hyst_reg};
            OFF_DEB:     reg_rdata <= {24'h000000, deb_reg};
            OFF_SCANRES: reg_rdata <= {27'h0000000, scanres_reg};
            OFF_ELEMS:   reg_rdata <= {26'h0000000, elems_reg};
            OFF_POSRES:  reg_rdata <= {24'h000000, posres_reg};
            OFF_GROUP:   reg_rdata <= {24'h000000, rows_reg, cols_reg};
            OFF_GENIDX:  reg_rdata <= {27'h0000000, genidx_reg};
            OFF_ACTIVE:  reg_rdata <= act_reg;
            OFF_POS:     reg_rdata <= {23'h000000, slider_touch, slider_pos};
            OFF_TPXY:    reg_rdata <= {16'h0000, tp_y, tp_x};
            OFF_GENRAW:  reg_rdata <= {16'h0000, generic_raw};
            OFF_STATUS:  reg_rdata <= {31'h00000000, cfg_err};
            default:     reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // per-sample baseline, difference, debounce and hysteresis decision
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bvalid_reg <= 32'h0000_0000;
         act_reg    <= 32'h0000_0000;
         for (int k = 0; k < NSENS; k++) begin
            base_mem[k] <= 16'h0000;
            diff_mem[k] <= 16'h0000;
            deb_mem[k]  <= 8'h00;
         end
      end else if (smp_valid) begin
         diff_mem[smp_idx] <= diff;
         if (!bvalid_reg[smp_idx]) begin
            base_mem[smp_idx]   <= raw_c;  // first sample seeds the baseline
            bvalid_reg[smp_idx] <= 1'b1;
         end else if (diff <= nz) begin
            base_mem[smp_idx] <= raw_c;
         end
         if (!act_c) begin
            if (17'(diff) > on_thr) begin
               if (deb_hit) begin
                  act_reg[smp_idx] <= 1'b1;
                  deb_mem[smp_idx] <= 8'h00;
               end else begin
                  deb_mem[smp_idx] <= deb_mem[smp_idx] + 8'h01;
               end
            end else begin
               deb_mem[smp_idx] <= 8'h00;  // streak broken, start over
            end
         end else if (diff < off_thr) begin
            act_reg[smp_idx] <= 1'b0;
         end
      end
   end

   // generic widget: unprocessed raw count
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         generic_raw <= 16'h0000;
      end else if (smp_valid && smp_idx == genidx_reg) begin
         generic_raw <= smp_raw;
      end
   end

   // matrix press at active row and active column crossings
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         matrix_press <= 64'h0000_0000_0000_0000;
      end else begin
         for (int r = 0; r < GRP_MAX; r++) begin
            for (int c = 0; c < GRP_MAX; c++) begin
               matrix_press[r*GRP_MAX+c] <= act_reg[ROW_BASE+5'(r)] &
                  act_reg[COL_BASE+5'(c)] & (4'(r) < rows_reg) & (4'(c) < cols_reg);
            end
         end
      end
   end

   // element count and current element difference for this pass
   always_comb begin
      case (pass_reg)
         2'h0:    cnt_c = cfg_err ? 6'h00 : elems_reg;
         2'h1:    cnt_c = {2'h0, cols_reg};
         default: cnt_c = {2'h0, rows_reg};
      endcase
      d_c = diff_mem[sens_of(pass_reg, i_reg, ctrl_reg[CTRL_DIPLEX], pins)];
   end

   // centroid: accumulate weighted sums, then divide by repeated subtraction;
   // slow (up to res cycles) but tiny, and frames are far longer
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cst_reg   <= CS_IDLE;
         pass_reg  <= 2'h0;
         i_reg     <= 6'h00;
         sw_reg    <= 21'h000000;
         num_reg   <= 40'h00_0000_0000;
         den_reg   <= 40'h00_0000_0000;
         q_reg     <= 8'h00;
         touch_reg <= 1'b0;
      end else begin
         case (cst_reg)
            CS_IDLE: begin
               if (frame_done) begin
                  cst_reg  <= CS_ACC;
                  pass_reg <= 2'h0;
                  i_reg    <= 6'h00;
                  sw_reg   <= 21'h000000;
                  num_reg  <= 40'h00_0000_0000;
               end
            end
            CS_ACC: begin
               if (i_reg < cnt_c) begin
                  if (d_c >= nz) begin
                     sw_reg  <= sw_reg + 21'(d_c);
                     num_reg <= num_reg + 40'(d_c) * 40'(i_reg);
                  end
                  i_reg <= i_reg + 6'h01;
               end else begin
                  num_reg   <= num_reg * 40'(posres_reg);
                  den_reg   <= 40'(sw_reg) * 40'(cnt_c - 6'h01);
                  q_reg     <= 8'h00;
                  touch_reg <= (sw_reg != 21'h000000) && (cnt_c > 6'h01);
                  cst_reg   <= CS_DIV;
               end
            end
            CS_DIV: begin
               if (touch_reg && num_reg >= den_reg && q_reg < posres_reg) begin
                  num_reg <= num_reg - den_reg;
                  q_reg   <= q_reg + 8'h01;
               end else begin
                  cst_reg <= CS_DONE;
               end
            end
            CS_DONE: begin
               i_reg   <= 6'h00;
               sw_reg  <= 21'h000000;
               num_reg <= 40'h00_0000_0000;
               if (pass_reg == 2'h2) begin
                  cst_reg <= CS_IDLE;
               end else begin
                  pass_reg <= pass_reg + 2'h1;
                  cst_reg  <= CS_ACC;
               end
            end
            default: cst_reg <= CS_IDLE;
         endcase
      end
   end

   // results per pass; slider goes through the position filter
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         slider_touch <= 1'b0;
         tp_x         <= 8'h00;
         tp_y         <= 8'h00;
         pf.vld       <= 1'b0;
         pf.clr       <= 1'b0;
         pf.din       <= 8'h00;
      end else begin
         pf.vld <= 1'b0;
         pf.clr <= 1'b0;
         if (cst_reg == CS_DONE) begin
            case (pass_reg)
               2'h0: begin
                  slider_touch <= touch_reg;
                  pf.vld       <= touch_reg;
                  pf.clr       <= !touch_reg;
                  pf.din       <= q_reg;
               end
               2'h1:    tp_x <= touch_reg ? q_reg : tp_x;
               default: tp_y <= touch_reg ? q_reg : tp_y;
            endcase
         end
      end
   end

   assign pf.sel        = ctrl_reg[CTRL_FLT_LO +: 3];
   assign slider_pos    = pf.dout;
   assign sensor_active = act_reg;

   twd_pos_filter u_filter (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .pf      (pf.flt)
   );

   // assertion helpers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) idx_q <= 5'h00;
      else       idx_q <= smp_idx;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_arm_done;
      smp_valid && !act_c && 17'(diff) > on_thr && deb_hit;
   endsequence

   property p_rise;
      s_arm_done |=> act_reg[idx_q];
   endproperty
   a_rise: assert property (p_rise) else $error("sensor not active after debounce");

   property p_no_arm;
      (smp_valid && !act_c && !(17'(diff) > on_thr)) |=> !act_reg[idx_q];
   endproperty
   a_no_arm: assert property (p_no_arm) else $error("activated below on level");

   property p_release;
      (smp_valid && act_c && diff < off_thr) |=> !act_reg[idx_q];
   endproperty
   a_release: assert property (p_release) else $error("active sensor not released");

   property p_base_hold;
      (smp_valid && bvalid_reg[smp_idx] && diff > nz) |=> base_mem[idx_q] == $past(bl);
   endproperty
   a_base_hold: assert property (p_base_hold) else $error("baseline moved above noise");

   // checked at the default 10-bit resolution, independent of the clamp function
   property p_raw_lim;
      (smp_valid && scanres_reg == SCANRES_RST) |->
         raw_c == ((smp_raw > 16'h03FF) ? 16'h03FF : smp_raw);
   endproperty
   a_raw_lim: assert property (p_raw_lim) else $error("raw count above scan limit");

   property p_generic;
      (smp_valid && smp_idx == genidx_reg) |=> generic_raw == $past(smp_raw);
   endproperty
   a_generic: assert property (p_generic) else $error("generic raw not passed");

   property p_pos_range;
      (cst_reg == CS_DONE) |-> q_reg <= posres_reg;
   endproperty
   a_pos_range: assert property (p_pos_range) else $error("position beyond range");

endmodule

// ### verif/twd_sense_fe.sv
// twd_sense_fe: scan front end model, one sample per request
// assumes requests at least two cycles apart, same clock as the block
`timescale 1ns/1ps
module twd_sense_fe #(
   parameter int NB = 10
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        go,
   input  wire logic [4:0]  idx,
   input  wire logic [15:0] raw,
   output logic             smp_valid,
   output logic      [4:0]  smp_idx,
   output logic      [15:0] smp_raw
);
   localparam logic [15:0] CAP = 16'((32'h1 << NB) - 1);
   // idle lines show the inverse so stale data never passes for a sample
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         smp_valid <= 1'b0;
         smp_idx   <= 5'h00;
         smp_raw   <= 16'h0000;
      end else begin
         smp_valid <= go;
         smp_idx   <= go ? idx : ~smp_idx;
         smp_raw   <= go ? ((raw > CAP) ? CAP : raw) : ~smp_raw;
      end
   end
endmodule

// ### verif/touch_widget_detector_tb.sv
// touch_widget_detector_tb: self-checking bench of twd_top
// assumes 10 MHz clock, one frame pass per filter choice except the half iir, jitter at the end
`timescale 1ns/1ps
module touch_widget_detector_tb;
   import twd_pkg::*;
   logic        clk_sys, rstn, reg_wr, reg_rd, go, fd, smp_valid, cfg_err, slider_touch;
   logic [7:0]  reg_addr, slider_pos, tp_x, tp_y;
   logic [31:0] reg_wdata, reg_rdata, sensor_active, st;
   logic [4:0]  idx, smp_idx;
   logic [15:0] raw, smp_raw, generic_raw;
   logic [63:0] matrix_press, mx;
   int base[32], cnt[32], dl[32], failures, comparisons, cyc, x, y;
   bit seen[32], act[32];
   int fl = 100, hy = 10, nl = 20, db = 5;
   int dr[] = '{200, 150, 260, 260, 260, 260, 260, 261, 261, 261, 261, 261, 241, 239};
   int ts[] = '{0, 1, 16, 17, 24, 26};
   twd_sense_fe FE (.clk_sys, .rstn, .go, .idx, .raw, .smp_valid, .smp_idx, .smp_raw);
   twd_top DUT (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .smp_valid, .smp_idx, .smp_raw, .frame_done(fd), .sensor_active, .slider_pos,
      .slider_touch, .tp_x, .tp_y, .matrix_press, .generic_raw, .cfg_err);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // expected touch state of one sensor after one sample
   function automatic bit step(int i, int r);
      int d;
      d = (!seen[i] || r < base[i]) ? 0 : r - base[i];
      dl[i] = d;
      if (!seen[i] || d <= nl) base[i] = r;
      seen[i] = 1'b1;
      if (!act[i]) begin
         cnt[i] = (d > fl + hy) ? cnt[i] + 1 : 0;
         act[i] = cnt[i] >= db;
      end else if (d < fl - hy) begin
         act[i] = 1'b0;
         cnt[i] = 0;
      end
      return act[i];
   endfunction
   // expected centroid of n elements from sensor b, capped at 100, -1 when untouched
   function automatic int cen(int b, int n, bit dx);
      int sw, nm, s, p;
      sw = 0;
      nm = 0;
      p = dx ? (n + 1) / 2 : n;
      for (int e = 0; e < n; e++) begin
         s = (dx && e >= p) ? b + e - p : b + e;
         if (dl[s] >= nl) begin
            sw += dl[s];
            nm += dl[s] * e;
         end
      end
      if (sw == 0) return -1;
      return (nm * 100 >= 100 * sw * (n - 1)) ? 100 : nm * 100 / (sw * (n - 1));
   endfunction
   function automatic logic [31:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   task automatic chk(string nm, logic [31:0] sv, logic [31:0] ev);
      comparisons++;
      if (sv !== ev) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, ev, sv);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   // set filter and diplex, pulse frame_done, wait out all three passes
   task automatic frame(logic [31:0] c);
      wr(OFF_CTRL, c);
      @(posedge clk_sys);
      fd <= 1'b1;
      @(posedge clk_sys);
      fd <= 1'b0;
      repeat (400) @(posedge clk_sys);
      #1;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk("rdata", reg_rdata, e);
   endtask
   task automatic smp(int i, int r);
      bit e;
      e = step(i, r);
      @(posedge clk_sys);
      go <= 1'b1;
      idx <= 5'(i);
      raw <= 16'(r);
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("active", {31'h0, sensor_active[i]}, {31'h0, e});
      if (i == 3) chk("generic", {16'h0, generic_raw}, 32'(r));
   endtask
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, far above the few thousand cycles needed
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      {rstn, reg_wr, reg_rd, go, fd, reg_addr, reg_wdata, idx, raw} = '0;
      st = 32'h0000004B;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(OFF_FINGER, 32'h64);
      rd(OFF_NOISE, 32'h14);
      rd(OFF_HYST, 32'h0A);
      rd(OFF_DEB, 32'h05);
      rd(OFF_SCANRES, 32'h0A);
      rd(OFF_ELEMS, 32'h05);
      rd(OFF_POSRES, 32'h64);
      rd(OFF_CTRL, 32'h40);
      rd(8'h2C, 32'h0);
      wr(OFF_GENIDX, 32'h3);
      foreach (dr[k]) smp(3, dr[k]);
      // recommended manual tuning, sum kept within the 8-bit limit
      wr(OFF_FINGER, 32'd80);
      wr(OFF_HYST, 32'd10);
      wr(OFF_DEB, 32'd3);
      fl = 80;
      db = 3;
      rd(OFF_FINGER, 32'd80);
      repeat (300) smp(4 + int'(rnd() % 4), 300 + int'(rnd() % 250));
      wr(OFF_ELEMS, 32'h1);
      chk("cfg_err", {31'h0, cfg_err}, 32'h1);
      wr(OFF_ELEMS, 32'h4);
      wr(OFF_CTRL, 32'h42);
      chk("cfg_err", {31'h0, cfg_err}, 32'h1);
      wr(OFF_ELEMS, 32'h5);
      rd(OFF_STATUS, 32'h0);
      // touches on two columns, two rows and the slider, then one frame per filter but the half iir
      foreach (ts[k]) begin
         smp(ts[k], 100);
         repeat (3) smp(ts[k], 200 + int'(rnd() % 200));
      end
      for (int b = 0; b < 64; b++) mx[b] = act[24 + b / 8] & act[16 + b % 8];
      chk("matrix_lo", matrix_press[31:0], mx[31:0]);
      chk("matrix_hi", matrix_press[63:32], mx[63:32]);
      x = cen(0, 5, 1'b0);
      y = cen(0, 5, 1'b1);
      frame(32'h00);
      chk("slider_touch", {31'h0, slider_touch}, 32'(x >= 0));
      chk("slider_pos", {24'h0, slider_pos}, 32'(x));
      chk("tp_x", {24'h0, tp_x}, 32'(cen(16, 8, 1'b0)));
      chk("tp_y", {24'h0, tp_y}, 32'(cen(24, 8, 1'b0)));
      frame(32'h42);
      chk("slider_pos", {24'h0, slider_pos}, 32'((y + 3 * x) / 4));
      frame(32'h20);
      chk("slider_pos", {24'h0, slider_pos}, 32'((2 * x + y) / 3));
      frame(32'h12);
      chk("slider_pos", {24'h0, slider_pos}, 32'(y));
      frame(32'h50);
      chk("slider_pos", {24'h0, slider_pos}, 32'(y + (x > y) - (x < y)));
      give_verdict();
   end
endmodule
